// [design/sea_pkg.sv]
// How it works
// - Group interrupt is the OR of all enabled sources: blocks, GPIOs, tachometers.
// - Interrupt pin active level follows its control polarity bit; default active low.
// - Interrupt pin control bit 7 picks open-drain or push-pull; default open-drain.
// - Group interrupt reaches its pin only while enable2 bit 7 is set.
// - Enable2 bit 6 also sends the group interrupt on serial IRQ slot 2.
// - Enable2 bit 5 feeds the group interrupt into the wake logic.
// - GPIO/tach status set on polarity-chosen edge; status AND enable raises interrupt.
// - Dual-edge GPIOs set their interrupt status on both edges.
// - GPIO interrupt status clears only on a written one.
// - Block sources other than infrared are live signals ANDed with enables, never latched.
// - Block status clears at its source; infrared status clears on status2 read.
// - Wake sources: rings, infrared frames, keyboard/mouse data, GPIO edges, tachometers.
// - Wake pin active level follows its control polarity bit; default active low.
// - Wake pin control bit 7 picks open-drain or push-pull; default open-drain.
// - Global wake enable gates the wake pin; clear means never asserted.
// - Global wake status sets from enabled source events, ignoring global enable.
// - Global wake status holds until every pending enabled status is cleared.
// - GPIO wake status set on chosen edge or both; cleared by written one.
// - Device-interrupt wake status follows routed group interrupt; written one clears it.
// - Device-interrupt wake enable and status together assert the wake pin while global wake enable is set.
// - Dual-edge GPIOs collect a per-pin status set on either edge, write-one clear.

package sea_pkg;

	// ------------------------------------------------------------
	// Register field positions
	// ------------------------------------------------------------
	localparam int CTRL_POLARITY_BIT = 1;
	localparam int CTRL_BUFFER_BIT = 7;
	localparam int EN2_PIN_BIT = 7;
	localparam int EN2_SERIRQ_BIT = 6;
	localparam int EN2_WAKE_BIT = 5;
	localparam int DEVICE_IRQ_WAKE_BIT = 3;

	// ------------------------------------------------------------
	// Miscellaneous wake source indices
	// ------------------------------------------------------------
	localparam int MISC_RING1 = 0;
	localparam int MISC_RING2 = 1;
	localparam int MISC_KBD = 2;
	localparam int MISC_MOUSE = 3;
	localparam int MISC_IR_FRAME = 4;
	localparam int MISC_W = 5;
	localparam int MISC_PIN_W = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic PIN_IDLE_OUT = 1'h1;
	localparam logic PIN_IDLE_OE = 1'h1;
	localparam logic STATUS_RESET = 1'h0;

	// Edge that qualifies a source: both edges win over polarity
	function automatic logic sea_edge_hit(input logic rise, input logic fall,
		input logic inverted, input logic dual);
		sea_edge_hit = dual ? (rise | fall) : (inverted ? fall : rise);
	endfunction

endpackage

// [design/sea_edge_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module sea_edge_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic [WIDTH-1:0] pin,
	// Edge pulses
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] prev;
		logic [2:0] primed;
	} sea_sync_type;

	sea_sync_type state;
	sea_sync_type next_state;

	if (WIDTH < 1)
		$error("sea_edge_sync: WIDTH must be at least 1");

	// ------------------------------------------------------------
	// Two-stage synchroniser, edge taken past the second stage
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.meta = pin;
		next_state.stable = state.meta;
		next_state.prev = state.stable;
		next_state.primed = {state.primed[1:0], 1'h1};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	// Meta stage never seen here, so one edge gives one pulse
	// No edge until all stages hold real samples: a pin idling high fakes none
	assign rise = state.stable & ~state.prev & {WIDTH{state.primed[2]}};
	assign fall = ~state.stable & state.prev & {WIDTH{state.primed[2]}};

endmodule // sea_edge_sync

`default_nettype wire

// [design/sea_pin_driver.sv]
`timescale 1ns/1ns
`default_nettype none

module sea_pin_driver (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request and pin control
	input wire logic active,
	input wire logic [7:0] ctrl,
	// Pin
	output logic pin_out,
	output logic pin_oe_n
);

	typedef struct packed {
		logic out;
		logic oe_n;
	} sea_pin_type;

	sea_pin_type state;
	sea_pin_type next_state;
	logic level;
	logic open_drain;

	// ------------------------------------------------------------
	// Level and buffer type
	// ------------------------------------------------------------
	always_comb
	begin
		// Polarity bit set means active high; clear gives active low
		level = ctrl[sea_pkg::CTRL_POLARITY_BIT] ? active : ~active;
		open_drain = ctrl[sea_pkg::CTRL_BUFFER_BIT];
		next_state.out = level;
		// Open drain only sinks; a high level is left to the pull-up
		next_state.oe_n = open_drain ? level : 1'h0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state.out <= sea_pkg::PIN_IDLE_OUT;
			state.oe_n <= sea_pkg::PIN_IDLE_OE;
		end
		else
			state <= next_state;
	end

	assign pin_out = state.out;
	assign pin_oe_n = state.oe_n;

endmodule // sea_pin_driver

`default_nettype wire

// [design/sea_aggregator.sv]
`timescale 1ns/1ns
`default_nettype none

module sea_aggregator #(
	parameter int N_FUNC = 5,
	parameter int N_GPIO = 19,
	parameter int N_TACH = 2
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,

	// Functional block sources
	input wire logic [N_FUNC-1:0] FUNC_IRQ,
	input wire logic [N_FUNC-1:0] FUNC_MGMT_EN,
	input wire logic INFRARED_IRQ_EVENT,
	input wire logic INFRARED_MGMT_EN,
	input wire logic MGMT_IRQ_STATUS_REG2_READ,
	output logic INFRARED_MGMT_STATUS,

	// GPIO pins and their settings
	input wire logic [N_GPIO-1:0] GPIO_IN,
	input wire logic [N_GPIO-1:0] GPIO_POLARITY,
	input wire logic [N_GPIO-1:0] DUAL_EDGE_TRIGGER,
	input wire logic [N_GPIO-1:0] GPIO_MGMT_EN,
	input wire logic [N_GPIO-1:0] GPIO_MGMT_CLR,
	output logic [N_GPIO-1:0] GPIO_MGMT_STATUS,
	input wire logic [N_GPIO-1:0] GPIO_WAKE_EN,
	input wire logic [N_GPIO-1:0] GPIO_WAKE_CLR,
	output logic [N_GPIO-1:0] GPIO_WAKE_STATUS,
	input wire logic [N_GPIO-1:0] DUAL_EDGE_STATUS_REG_CLR,
	output logic [N_GPIO-1:0] DUAL_EDGE_STATUS_REG,

	// Fan tachometer inputs
	input wire logic [N_TACH-1:0] TACH_IN,
	input wire logic [N_TACH-1:0] TACH_POLARITY,
	input wire logic [N_TACH-1:0] TACH_MGMT_EN,
	input wire logic [N_TACH-1:0] TACH_MGMT_CLR,
	output logic [N_TACH-1:0] TACH_MGMT_STATUS,
	input wire logic [N_TACH-1:0] TACH_WAKE_EN,
	input wire logic [N_TACH-1:0] TACH_WAKE_CLR,
	output logic [N_TACH-1:0] TACH_WAKE_STATUS,

	// Other wake sources
	input wire logic RING_INDICATOR_PORT1_N,
	input wire logic RING_INDICATOR_PORT2_N,
	input wire logic KBD_DATA,
	input wire logic MOUSE_DATA,
	input wire logic INFRARED_FRAME_VALID,
	input wire logic [sea_pkg::MISC_W-1:0] MISC_WAKE_EN,
	input wire logic [sea_pkg::MISC_W-1:0] MISC_WAKE_CLR,
	output logic [sea_pkg::MISC_W-1:0] MISC_WAKE_STATUS,

	// Routing and wake control
	input wire logic [7:0] MGMT_IRQ_ENABLE_REG2,
	input wire logic DEVICE_IRQ_WAKE_ENABLE,
	input wire logic DEVICE_IRQ_WAKE_CLR,
	output logic DEVICE_IRQ_WAKE_STATUS,
	input wire logic WAKE_GLOBAL_ENABLE,
	output logic WAKE_GLOBAL_STATUS,
	input wire logic [7:0] MGMT_IRQ_PIN_GPIO_CTRL,
	input wire logic [7:0] WAKE_PIN_GPIO_CTRL,

	// Outputs to the host chipset
	output logic GROUP_MGMT_IRQ_INTERNAL,
	output logic SERIRQ_SLOT2_REQ,
	output logic GROUP_MGMT_IRQ_PIN_OUT,
	output logic GROUP_MGMT_IRQ_PIN_OE_N,
	output logic WAKE_EVENT_PIN_OUT,
	output logic WAKE_EVENT_PIN_OE_N
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (N_FUNC < 1)
		$error("sea_aggregator: N_FUNC must be at least 1");
	if (N_GPIO < 1)
		$error("sea_aggregator: N_GPIO must be at least 1");
	if (N_TACH < 1)
		$error("sea_aggregator: N_TACH must be at least 1");

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic ir_sts;
		logic [N_GPIO-1:0] gpio_mgmt_sts;
		logic [N_GPIO-1:0] gpio_wake_sts;
		logic [N_GPIO-1:0] dual_sts;
		logic [N_TACH-1:0] tach_mgmt_sts;
		logic [N_TACH-1:0] tach_wake_sts;
		logic [sea_pkg::MISC_W-1:0] misc_wake_sts;
		logic dev_wake_sts;
		logic wake_global_sts;
		logic group_irq;
		logic serirq;
		logic pin_irq_active;
		logic wake_active;
	} sea_state_type;

	sea_state_type state;
	sea_state_type next_state;
	logic [1:0] rst_pipe;
	logic rst_n;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Assert at once, release only after two clean edges
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'h1};
	end

	assign rst_n = rst_pipe[1];

	// ------------------------------------------------------------
	// Pin synchronisers and edge detectors
	// ------------------------------------------------------------
	logic [N_GPIO-1:0] gpio_rise;
	logic [N_GPIO-1:0] gpio_fall;
	logic [N_TACH-1:0] tach_rise;
	logic [N_TACH-1:0] tach_fall;
	logic [sea_pkg::MISC_PIN_W-1:0] misc_pin;
	logic [sea_pkg::MISC_PIN_W-1:0] misc_rise;
	logic [sea_pkg::MISC_PIN_W-1:0] misc_fall;

	assign misc_pin = {MOUSE_DATA, KBD_DATA, RING_INDICATOR_PORT2_N, RING_INDICATOR_PORT1_N};

	sea_edge_sync #(.WIDTH(N_GPIO)) u_gpio_sync (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.pin(GPIO_IN),
		.rise(gpio_rise),
		.fall(gpio_fall)
	);

	sea_edge_sync #(.WIDTH(N_TACH)) u_tach_sync (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.pin(TACH_IN),
		.rise(tach_rise),
		.fall(tach_fall)
	);

	sea_edge_sync #(.WIDTH(sea_pkg::MISC_PIN_W)) u_misc_sync (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.pin(misc_pin),
		.rise(misc_rise),
		.fall(misc_fall)
	);

	// ------------------------------------------------------------
	// Qualifying edges
	// ------------------------------------------------------------
	logic [N_GPIO-1:0] gpio_hit;
	logic [N_GPIO-1:0] gpio_any_edge;
	logic [N_TACH-1:0] tach_hit;
	logic [sea_pkg::MISC_W-1:0] misc_hit;

	always_comb
	begin
		for (int i = 0; i < N_GPIO; i++)
		begin
			gpio_hit[i] = sea_pkg::sea_edge_hit(gpio_rise[i], gpio_fall[i],
				GPIO_POLARITY[i], DUAL_EDGE_TRIGGER[i]);
			gpio_any_edge[i] = DUAL_EDGE_TRIGGER[i] & (gpio_rise[i] | gpio_fall[i]);
		end
		for (int i = 0; i < N_TACH; i++)
			tach_hit[i] = sea_pkg::sea_edge_hit(tach_rise[i], tach_fall[i],
				TACH_POLARITY[i], 1'h0);
		// Rings and data lines are active low: the falling edge counts
		misc_hit[sea_pkg::MISC_RING1] = misc_fall[sea_pkg::MISC_RING1];
		misc_hit[sea_pkg::MISC_RING2] = misc_fall[sea_pkg::MISC_RING2];
		misc_hit[sea_pkg::MISC_KBD] = misc_fall[sea_pkg::MISC_KBD];
		misc_hit[sea_pkg::MISC_MOUSE] = misc_fall[sea_pkg::MISC_MOUSE];
		misc_hit[sea_pkg::MISC_IR_FRAME] = INFRARED_FRAME_VALID;
	end

	// ------------------------------------------------------------
	// Group interrupt and wake logic
	// ------------------------------------------------------------
	logic group_now;
	logic wake_pending;
	logic route_wake;

	always_comb
	begin
		next_state = state;

		// Set wins over a clear in the same cycle
		next_state.ir_sts = INFRARED_IRQ_EVENT
			| (state.ir_sts & ~MGMT_IRQ_STATUS_REG2_READ);
		next_state.gpio_mgmt_sts = gpio_hit | (state.gpio_mgmt_sts & ~GPIO_MGMT_CLR);
		next_state.tach_mgmt_sts = tach_hit | (state.tach_mgmt_sts & ~TACH_MGMT_CLR);
		next_state.gpio_wake_sts = gpio_hit | (state.gpio_wake_sts & ~GPIO_WAKE_CLR);
		next_state.tach_wake_sts = tach_hit | (state.tach_wake_sts & ~TACH_WAKE_CLR);
		next_state.misc_wake_sts = misc_hit
			| (state.misc_wake_sts & ~MISC_WAKE_CLR);
		next_state.dual_sts = gpio_any_edge | (state.dual_sts & ~DUAL_EDGE_STATUS_REG_CLR);

		// Block requests are live; only infrared is held
		group_now = (|(FUNC_IRQ & FUNC_MGMT_EN))
			| (state.ir_sts & INFRARED_MGMT_EN)
			| (|(state.gpio_mgmt_sts & GPIO_MGMT_EN))
			| (|(state.tach_mgmt_sts & TACH_MGMT_EN));
		next_state.group_irq = group_now;

		next_state.pin_irq_active = state.group_irq
			& MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_PIN_BIT];
		next_state.serirq = state.group_irq
			& MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_SERIRQ_BIT];

		route_wake = state.group_irq & MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_WAKE_BIT];
		next_state.dev_wake_sts = route_wake
			| (state.dev_wake_sts & ~DEVICE_IRQ_WAKE_CLR);

		wake_pending = (|(state.gpio_wake_sts & GPIO_WAKE_EN))
			| (|(state.tach_wake_sts & TACH_WAKE_EN))
			| (|(state.misc_wake_sts & MISC_WAKE_EN))
			| (state.dev_wake_sts & DEVICE_IRQ_WAKE_ENABLE);
		// Held by pending bits alone, whatever the global enable
		next_state.wake_global_sts = wake_pending;
		next_state.wake_active = wake_pending & WAKE_GLOBAL_ENABLE;
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	sea_pin_driver u_irq_pin (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.active(state.pin_irq_active),
		.ctrl(MGMT_IRQ_PIN_GPIO_CTRL),
		.pin_out(GROUP_MGMT_IRQ_PIN_OUT),
		.pin_oe_n(GROUP_MGMT_IRQ_PIN_OE_N)
	);

	sea_pin_driver u_wake_pin (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.active(state.wake_active),
		.ctrl(WAKE_PIN_GPIO_CTRL),
		.pin_out(WAKE_EVENT_PIN_OUT),
		.pin_oe_n(WAKE_EVENT_PIN_OE_N)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign INFRARED_MGMT_STATUS = state.ir_sts;
	assign GPIO_MGMT_STATUS = state.gpio_mgmt_sts;
	assign GPIO_WAKE_STATUS = state.gpio_wake_sts;
	assign DUAL_EDGE_STATUS_REG = state.dual_sts;
	assign TACH_MGMT_STATUS = state.tach_mgmt_sts;
	assign TACH_WAKE_STATUS = state.tach_wake_sts;
	assign MISC_WAKE_STATUS = state.misc_wake_sts;
	assign DEVICE_IRQ_WAKE_STATUS = state.dev_wake_sts;
	assign WAKE_GLOBAL_STATUS = state.wake_global_sts;
	assign GROUP_MGMT_IRQ_INTERNAL = state.group_irq;
	assign SERIRQ_SLOT2_REQ = state.serirq;

endmodule // sea_aggregator

`default_nettype wire

// [verification/sea_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sea_host_model (
	// Device pins
	input wire logic irq_out,
	input wire logic irq_oe_n,
	input wire logic wake_out,
	input wire logic wake_oe_n,
	// Wire levels
	output logic irq_level,
	output logic wake_level
);
	// Board pull-ups hold a released line high
	assign irq_level = irq_oe_n | irq_out;
	assign wake_level = wake_oe_n | wake_out;
endmodule // sea_host_model

`default_nettype wire

// [verification/sea_props.sv]
`timescale 1ns/1ns
`default_nettype none

module sea_props #(
	parameter int N_FUNC = 5,
	parameter int N_GPIO = 19
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// Settings
	input wire logic [N_FUNC-1:0] FUNC_IRQ,
	input wire logic [N_FUNC-1:0] FUNC_MGMT_EN,
	input wire logic [N_GPIO-1:0] GPIO_MGMT_EN,
	input wire logic [N_GPIO-1:0] GPIO_MGMT_CLR,
	input wire logic [7:0] MGMT_IRQ_ENABLE_REG2,
	input wire logic [7:0] MGMT_IRQ_PIN_GPIO_CTRL,
	input wire logic [7:0] WAKE_PIN_GPIO_CTRL,
	input wire logic DEVICE_IRQ_WAKE_ENABLE,
	input wire logic WAKE_GLOBAL_ENABLE,
	// Device outputs
	input wire logic [N_GPIO-1:0] GPIO_MGMT_STATUS,
	input wire logic DEVICE_IRQ_WAKE_STATUS,
	input wire logic WAKE_GLOBAL_STATUS,
	input wire logic GROUP_MGMT_IRQ_INTERNAL,
	input wire logic SERIRQ_SLOT2_REQ,
	input wire logic GROUP_MGMT_IRQ_PIN_OUT,
	input wire logic GROUP_MGMT_IRQ_PIN_OE_N,
	input wire logic WAKE_EVENT_PIN_OUT,
	input wire logic WAKE_EVENT_PIN_OE_N
);
	logic irq_act, wake_act, irq_route, wake_route, dev_wake;
	logic slot_route;
	logic [2:0] rst_seen;

	// Design holds its own reset two edges past the pin; outputs settle one later
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
			rst_seen <= 3'h0;
		else
			rst_seen <= {rst_seen[1:0], 1'h1};
	end

	// Active means the pulled-up wire sits at the polarity level
	assign irq_act = (GROUP_MGMT_IRQ_PIN_OE_N | GROUP_MGMT_IRQ_PIN_OUT) == MGMT_IRQ_PIN_GPIO_CTRL[1];
	assign wake_act = (WAKE_EVENT_PIN_OE_N | WAKE_EVENT_PIN_OUT) == WAKE_PIN_GPIO_CTRL[1];
	assign irq_route = GROUP_MGMT_IRQ_INTERNAL & MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_PIN_BIT];
	assign wake_route = GROUP_MGMT_IRQ_INTERNAL & MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_WAKE_BIT];
	assign dev_wake = DEVICE_IRQ_WAKE_STATUS & DEVICE_IRQ_WAKE_ENABLE;
	assign slot_route = GROUP_MGMT_IRQ_INTERNAL & MGMT_IRQ_ENABLE_REG2[sea_pkg::EN2_SERIRQ_BIT];

	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!rst_seen[2]);

	a_func_or: assert property (|(FUNC_IRQ & FUNC_MGMT_EN) |=> GROUP_MGMT_IRQ_INTERNAL)
		else $error("enabled block request gave no group irq");
	a_gpio_or: assert property (|(GPIO_MGMT_STATUS & GPIO_MGMT_EN)
		|=> GROUP_MGMT_IRQ_INTERNAL)
		else $error("enabled gpio status gave no group irq");
	a_gpio_sticky: assert property (($past(GPIO_MGMT_STATUS) & ~$past(GPIO_MGMT_CLR)
		& ~GPIO_MGMT_STATUS) == '0)
		else $error("gpio status fell without a clear");
	a_serirq_slot: assert property (SERIRQ_SLOT2_REQ == $past(slot_route))
		else $error("serial slot request wrong");
	a_dev_wake_set: assert property (wake_route |=> DEVICE_IRQ_WAKE_STATUS)
		else $error("device wake status not set");
	a_dev_wake_cause: assert property ($rose(DEVICE_IRQ_WAKE_STATUS) |-> $past(wake_route))
		else $error("device wake status set without cause");
	a_pin_route: assert property ($stable(MGMT_IRQ_PIN_GPIO_CTRL)
		|-> irq_act == $past(irq_route, 2))
		else $error("irq pin does not follow routed group irq");
	a_od_irq: assert property ($stable(MGMT_IRQ_PIN_GPIO_CTRL) && MGMT_IRQ_PIN_GPIO_CTRL[7]
		|-> GROUP_MGMT_IRQ_PIN_OE_N || !GROUP_MGMT_IRQ_PIN_OUT)
		else $error("open-drain irq pin drove high");
	a_pp_irq: assert property ($stable(MGMT_IRQ_PIN_GPIO_CTRL) && !MGMT_IRQ_PIN_GPIO_CTRL[7]
		|-> !GROUP_MGMT_IRQ_PIN_OE_N)
		else $error("push-pull irq pin not driven");
	a_od_wake: assert property ($stable(WAKE_PIN_GPIO_CTRL) && WAKE_PIN_GPIO_CTRL[7]
		|-> WAKE_EVENT_PIN_OE_N || !WAKE_EVENT_PIN_OUT)
		else $error("open-drain wake pin drove high");
	a_wake_gate: assert property ((!WAKE_GLOBAL_ENABLE) [*3] |-> !wake_act)
		else $error("wake pin active with global enable clear");
	a_wake_dev: assert property ((dev_wake & WAKE_GLOBAL_ENABLE) [*4] |-> wake_act)
		else $error("device wake did not assert wake pin");
	a_wake_status: assert property (dev_wake |=> WAKE_GLOBAL_STATUS)
		else $error("global wake status not set");

	c_irq: cover property ($rose(GROUP_MGMT_IRQ_INTERNAL));
	c_wake: cover property ($rose(wake_act));
	c_dev: cover property ($rose(DEVICE_IRQ_WAKE_STATUS));
endmodule // sea_props

bind sea_aggregator sea_props #(.N_FUNC(N_FUNC), .N_GPIO(N_GPIO)) sea_props_i (.*);

`default_nettype wire

// [verification/tb_sea_aggregator.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_sea_aggregator;
	logic REF_CLK, RSTN, INFRARED_IRQ_EVENT, INFRARED_MGMT_EN, MGMT_IRQ_STATUS_REG2_READ;
	logic RING_INDICATOR_PORT1_N, RING_INDICATOR_PORT2_N, KBD_DATA, MOUSE_DATA;
	logic INFRARED_FRAME_VALID, DEVICE_IRQ_WAKE_ENABLE, DEVICE_IRQ_WAKE_CLR, WAKE_GLOBAL_ENABLE;
	logic INFRARED_MGMT_STATUS, DEVICE_IRQ_WAKE_STATUS, WAKE_GLOBAL_STATUS, irq_level;
	logic GROUP_MGMT_IRQ_INTERNAL, SERIRQ_SLOT2_REQ, GROUP_MGMT_IRQ_PIN_OUT, wake_level;
	logic GROUP_MGMT_IRQ_PIN_OE_N, WAKE_EVENT_PIN_OUT, WAKE_EVENT_PIN_OE_N;
	logic [4:0] FUNC_IRQ, FUNC_MGMT_EN, MISC_WAKE_EN, MISC_WAKE_CLR, MISC_WAKE_STATUS;
	logic [18:0] GPIO_IN, GPIO_POLARITY, DUAL_EDGE_TRIGGER, GPIO_MGMT_EN, GPIO_MGMT_CLR;
	logic [18:0] GPIO_WAKE_EN, GPIO_WAKE_CLR, DUAL_EDGE_STATUS_REG_CLR, GPIO_MGMT_STATUS;
	logic [18:0] GPIO_WAKE_STATUS, DUAL_EDGE_STATUS_REG;
	logic [1:0] TACH_IN, TACH_POLARITY, TACH_MGMT_EN, TACH_MGMT_CLR, TACH_WAKE_EN;
	logic [1:0] TACH_WAKE_CLR, TACH_MGMT_STATUS, TACH_WAKE_STATUS;
	logic [7:0] MGMT_IRQ_ENABLE_REG2, MGMT_IRQ_PIN_GPIO_CTRL, WAKE_PIN_GPIO_CTRL;
	int err_total = 0;
	int check_count = 0;

	sea_aggregator sea_aggregator_i (.*);

	sea_host_model sea_host_model_i (
		.irq_out(GROUP_MGMT_IRQ_PIN_OUT),
		.irq_oe_n(GROUP_MGMT_IRQ_PIN_OE_N),
		.wake_out(WAKE_EVENT_PIN_OUT),
		.wake_oe_n(WAKE_EVENT_PIN_OE_N),
		.irq_level(irq_level),
		.wake_level(wake_level)
	);

	task automatic step(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask

	// Outputs settle just after the edge
	task automatic look(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		REF_CLK = 1'h0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	initial
	begin
		repeat (20000) @(posedge REF_CLK);
		err_total++;
		conclude;
	end

	initial
	begin
		{RSTN, INFRARED_IRQ_EVENT, INFRARED_MGMT_EN, MGMT_IRQ_STATUS_REG2_READ} = '0;
		{INFRARED_FRAME_VALID, DEVICE_IRQ_WAKE_ENABLE, DEVICE_IRQ_WAKE_CLR, WAKE_GLOBAL_ENABLE} = '0;
		{FUNC_IRQ, FUNC_MGMT_EN, MISC_WAKE_EN, MISC_WAKE_CLR, MGMT_IRQ_ENABLE_REG2} = '0;
		{GPIO_IN, GPIO_POLARITY, DUAL_EDGE_TRIGGER, GPIO_MGMT_EN, GPIO_MGMT_CLR} = '0;
		{GPIO_WAKE_EN, GPIO_WAKE_CLR, DUAL_EDGE_STATUS_REG_CLR} = '0;
		{TACH_IN, TACH_POLARITY, TACH_MGMT_EN, TACH_MGMT_CLR, TACH_WAKE_EN, TACH_WAKE_CLR} = '0;
		{RING_INDICATOR_PORT1_N, RING_INDICATOR_PORT2_N, KBD_DATA, MOUSE_DATA} = 4'hF;
		MGMT_IRQ_PIN_GPIO_CTRL = 8'h80;
		WAKE_PIN_GPIO_CTRL = 8'h80;
		step(10);
		RSTN <= 1'h1;
		look(3);
		chk("irq pin", 32'h1, irq_level);
		chk("wake pin", 32'h1, wake_level);
		step(1);
		FUNC_MGMT_EN <= 5'h14;
		FUNC_IRQ <= 5'h0B;
		look(3);
		chk("masked block", 32'h0, GROUP_MGMT_IRQ_INTERNAL);
		step(1);
		FUNC_IRQ <= 5'h10;
		look(2);
		chk("block irq", 32'h1, GROUP_MGMT_IRQ_INTERNAL);
		step(1);
		FUNC_IRQ <= 5'h00;
		look(2);
		chk("block drop", 32'h0, GROUP_MGMT_IRQ_INTERNAL);
		// ----
		// Bit 0 rising, bit 1 both edges, bit 2 falling
		// ----
		step(1);
		GPIO_POLARITY <= 19'h00004;
		DUAL_EDGE_TRIGGER <= 19'h00002;
		GPIO_IN <= 19'h00007;
		look(6);
		chk("mgmt sts", 32'h3, GPIO_MGMT_STATUS);
		chk("wake sts", 32'h3, GPIO_WAKE_STATUS);
		chk("dual sts", 32'h2, DUAL_EDGE_STATUS_REG);
		chk("gpio masked", 32'h0, GROUP_MGMT_IRQ_INTERNAL);
		step(1);
		GPIO_MGMT_CLR <= 19'h00002;
		GPIO_WAKE_CLR <= 19'h00003;
		DUAL_EDGE_STATUS_REG_CLR <= 19'h00002;
		step(1);
		{GPIO_MGMT_CLR, GPIO_WAKE_CLR, DUAL_EDGE_STATUS_REG_CLR} <= '0;
		look(2);
		chk("mgmt clr", 32'h1, GPIO_MGMT_STATUS);
		chk("wake clr", 32'h0, GPIO_WAKE_STATUS);
		chk("dual clr", 32'h0, DUAL_EDGE_STATUS_REG);
		step(1);
		GPIO_IN <= 19'h00000;
		look(6);
		chk("mgmt fall", 32'h7, GPIO_MGMT_STATUS);
		chk("dual fall", 32'h2, DUAL_EDGE_STATUS_REG);
		// ----
		// Group irq routing
		// ----
		step(1);
		GPIO_MGMT_EN <= 19'h00004;
		MGMT_IRQ_ENABLE_REG2 <= 8'hE0;
		look(7);
		chk("group irq", 32'h1, GROUP_MGMT_IRQ_INTERNAL);
		chk("slot 2", 32'h1, SERIRQ_SLOT2_REQ);
		chk("irq pin low", 32'h0, irq_level);
		chk("dev wake", 32'h1, DEVICE_IRQ_WAKE_STATUS);
		chk("wake unenabled", 32'h0, WAKE_GLOBAL_STATUS);
		step(1);
		MGMT_IRQ_PIN_GPIO_CTRL <= 8'h02;
		DEVICE_IRQ_WAKE_ENABLE <= 1'h1;
		look(4);
		chk("irq pin high", 32'h1, irq_level);
		chk("push-pull", 32'h0, GROUP_MGMT_IRQ_PIN_OE_N);
		chk("wake sts", 32'h1, WAKE_GLOBAL_STATUS);
		chk("wake gated", 32'h1, wake_level);
		step(1);
		WAKE_GLOBAL_ENABLE <= 1'h1;
		look(4);
		chk("dev wake pin", 32'h0, wake_level);
		step(1);
		MGMT_IRQ_ENABLE_REG2 <= 8'h80;
		MGMT_IRQ_PIN_GPIO_CTRL <= 8'h80;
		look(3);
		chk("slot 2 off", 32'h0, SERIRQ_SLOT2_REQ);
		chk("dev wake held", 32'h1, DEVICE_IRQ_WAKE_STATUS);
		step(1);
		DEVICE_IRQ_WAKE_CLR <= 1'h1;
		GPIO_MGMT_CLR <= 19'h00007;
		step(1);
		DEVICE_IRQ_WAKE_CLR <= 1'h0;
		GPIO_MGMT_CLR <= '0;
		look(4);
		chk("dev wake clr", 32'h0, DEVICE_IRQ_WAKE_STATUS);
		chk("irq clr", 32'h0, GROUP_MGMT_IRQ_INTERNAL);
		chk("irq pin idle", 32'h1, irq_level);
		chk("wake sts clr", 32'h0, WAKE_GLOBAL_STATUS);
		// ----
		// Ring, keyboard, mouse and infrared frame wake
		// ----
		step(1);
		MISC_WAKE_EN <= 5'h1F;
		{RING_INDICATOR_PORT1_N, RING_INDICATOR_PORT2_N, KBD_DATA, MOUSE_DATA} <= 4'h0;
		INFRARED_FRAME_VALID <= 1'h1;
		step(1);
		INFRARED_FRAME_VALID <= 1'h0;
		look(5);
		chk("misc sts", 32'h1F, MISC_WAKE_STATUS);
		chk("misc wake pin", 32'h0, wake_level);
		step(1);
		MISC_WAKE_CLR <= 5'h0F;
		step(1);
		MISC_WAKE_CLR <= 5'h00;
		look(3);
		chk("wake pending", 32'h1, WAKE_GLOBAL_STATUS);
		step(1);
		MISC_WAKE_CLR <= 5'h10;
		step(1);
		MISC_WAKE_CLR <= 5'h00;
		look(3);
		chk("wake released", 32'h0, WAKE_GLOBAL_STATUS);
		chk("wake pin off", 32'h1, wake_level);
		// ----
		// Tachometer and infrared block events
		// ----
		step(1);
		TACH_MGMT_EN <= 2'h1;
		TACH_POLARITY <= 2'h2;
		TACH_IN <= 2'h3;
		look(6);
		chk("tach sts", 32'h1, TACH_MGMT_STATUS);
		chk("tach irq", 32'h1, GROUP_MGMT_IRQ_INTERNAL);
		chk("tach wake", 32'h1, TACH_WAKE_STATUS);
		step(1);
		TACH_MGMT_CLR <= 2'h3;
		INFRARED_MGMT_EN <= 1'h1;
		INFRARED_IRQ_EVENT <= 1'h1;
		step(1);
		TACH_MGMT_CLR <= 2'h0;
		INFRARED_IRQ_EVENT <= 1'h0;
		look(3);
		chk("ir sts", 32'h1, INFRARED_MGMT_STATUS);
		chk("ir irq", 32'h1, GROUP_MGMT_IRQ_INTERNAL);
		step(1);
		MGMT_IRQ_STATUS_REG2_READ <= 1'h1;
		step(1);
		MGMT_IRQ_STATUS_REG2_READ <= 1'h0;
		look(3);
		chk("ir read", 32'h0, INFRARED_MGMT_STATUS);
		chk("irq idle", 32'h0, GROUP_MGMT_IRQ_INTERNAL);
		// ----
		// Held gpio wake status on an active-high push-pull wake pin
		// ----
		step(1);
		GPIO_WAKE_EN <= 19'h00004;
		WAKE_PIN_GPIO_CTRL <= 8'h02;
		look(4);
		chk("gpio wake", 32'h1, WAKE_GLOBAL_STATUS);
		chk("wake pin high", 32'h1, wake_level);
		chk("wake push-pull", 32'h0, WAKE_EVENT_PIN_OE_N);
		step(1);
		RSTN <= 1'h0;
		step(2);
		RSTN <= 1'h1;
		look(3);
		chk("sts after reset", 32'h0, GPIO_WAKE_STATUS);
		conclude;
	end
endmodule // tb_sea_aggregator

`default_nettype wire
